// *** hdl/compare_step_pkg.sv ***
`default_nettype none
package compare_step_pkg;

  // Register byte offsets on the APB port
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_OPCODE  = 8'h04;
  localparam logic [7:0] OFS_ACC     = 8'h08;
  localparam logic [7:0] OFS_POINTER = 8'h0c;
  localparam logic [7:0] OFS_COUNTER = 8'h10;
  localparam logic [7:0] OFS_FLAGS   = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_DATA    = 8'h1c;

  // Two-byte opcode of the compare step, first byte in the high half
  localparam logic [15:0] COMPARE_STEP_OP = 16'heda1;

  // Field positions
  localparam int CTRL_START   = 0;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DONE    = 1;
  localparam int STAT_BAD_OP  = 2;

  // Reset values
  localparam logic [7:0]  RST_ACC     = 8'h00;
  localparam logic [15:0] RST_POINTER = 16'h0000;
  localparam logic [15:0] RST_COUNTER = 16'h0000;
  localparam logic [7:0]  RST_FLAGS   = 8'h00;
  localparam logic [15:0] RST_OPCODE  = 16'h0000;
  localparam logic [7:0]  RST_DATA    = 8'h00;

  // Flag byte, bit 7 down to bit 0
  typedef struct packed {
    logic sign;
    logic zero;
    logic spare5;
    logic half;
    logic spare3;
    logic count_nz;
    logic subtract;
    logic carry;
  } flags_t;

  // Read request towards data memory
  typedef struct packed {
    logic        req;
    logic [15:0] addr;
  } mem_rd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_EXEC = 2'b10
  } step_state_t;

endpackage
`default_nettype wire

// *** hdl/step_alu.sv ***
`default_nettype none
module step_alu
  import compare_step_pkg::*;
(
  input  wire logic [7:0]  acc,
  input  wire logic [7:0]  mem_byte,
  input  wire flags_t      flags_in,
  input  wire logic [15:0] pointer_in,
  input  wire logic [15:0] count_in,
  output flags_t           flags_out,
  output logic      [15:0] pointer_out,
  output logic      [15:0] count_out
);

  logic [8:0] diff;
  logic [4:0] low_diff;

  always_comb begin
    diff        = {1'b0, acc} - {1'b0, mem_byte};
    low_diff    = {1'b0, acc[3:0]} - {1'b0, mem_byte[3:0]};
    pointer_out = 16'(pointer_in + 16'h0001);
    count_out   = 16'(count_in - 16'h0001);
    flags_out   = flags_in;
    flags_out.sign     = diff[7];
    flags_out.zero     = (diff[7:0] == 8'h00);
    flags_out.half     = low_diff[4];
    flags_out.count_nz = (count_out != 16'h0000);
    flags_out.subtract = 1'b1;
    flags_out.carry    = flags_in.carry;
  end

endmodule
`default_nettype wire

// *** hdl/compare_and_step_unit.sv ***
// Register access over APB and the address map were left to the implementer.
`default_nettype none
module compare_and_step_unit
  import compare_step_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output mem_rd_t                mem_rd,
  input  wire logic [7:0]        mem_rdata,
  input  wire logic              mem_ack,
  output logic                   busy
);

  step_state_t state_q;
  logic [7:0]  acc_q;
  logic [15:0] pointer_q;
  logic [15:0] counter_q;
  flags_t      flags_q;
  logic [15:0] opcode_q;
  logic [7:0]  data_q;
  logic        done_q;
  logic        bad_op_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  mem_rd_t     mem_rd_q;
  logic        busy_q;

  flags_t      flags_d;
  logic [15:0] pointer_d;
  logic [15:0] counter_d;

  logic setup;
  logic wr_en;
  logic start;
  logic op_ok;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = 8'(a);
    mapped = (o == OFS_CTRL) || (o == OFS_OPCODE) || (o == OFS_ACC)
          || (o == OFS_POINTER) || (o == OFS_COUNTER) || (o == OFS_FLAGS)
          || (o == OFS_STATUS) || (o == OFS_DATA);
  endfunction

  function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                  input logic [7:0] ofs);
    is_reg = (8'(a) == ofs);
  endfunction

  assign setup = psel && !penable;
  // Write lands at the access edge; operand writes refused while busy
  assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
  assign start = wr_en && is_reg(paddr, OFS_CTRL) && pwdata[CTRL_START]
              && (state_q == ST_IDLE);
  assign op_ok = (opcode_q == COMPARE_STEP_OP);

  step_alu u_alu (
    .acc         (acc_q),
    .mem_byte    (data_q),
    .flags_in    (flags_q),
    .pointer_in  (pointer_q),
    .count_in    (counter_q),
    .flags_out   (flags_d),
    .pointer_out (pointer_d),
    .count_out   (counter_d)
  );

  // APB answer: registered in setup, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (setup) begin
      pready_q  <= 1'b1;
      pslverr_q <= !mapped(paddr) || (pwrite && (state_q != ST_IDLE)
                   && !is_reg(paddr, OFS_CTRL) && !is_reg(paddr, OFS_STATUS));
      if (pwrite) begin
        prdata_q <= 32'h0000_0000;
      end else if (is_reg(paddr, OFS_OPCODE)) begin
        prdata_q <= {16'h0000, opcode_q};
      end else if (is_reg(paddr, OFS_ACC)) begin
        prdata_q <= {24'h000000, acc_q};
      end else if (is_reg(paddr, OFS_POINTER)) begin
        prdata_q <= {16'h0000, pointer_q};
      end else if (is_reg(paddr, OFS_COUNTER)) begin
        prdata_q <= {16'h0000, counter_q};
      end else if (is_reg(paddr, OFS_FLAGS)) begin
        prdata_q <= {24'h000000, flags_q};
      end else if (is_reg(paddr, OFS_STATUS)) begin
        prdata_q <= {29'h0000_0000, bad_op_q, done_q, busy_q};
      end else if (is_reg(paddr, OFS_DATA)) begin
        prdata_q <= {24'h000000, data_q};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Sequencer: read the byte, then execute in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start && op_ok) begin
            state_q <= ST_READ;
          end
        end
        ST_READ: begin
          if (mem_ack) begin
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // read request at the string pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rd_q <= '0;
    end else if (state_q == ST_IDLE && start && op_ok) begin
      mem_rd_q.req  <= 1'b1;
      mem_rd_q.addr <= pointer_q;
    end else if (state_q == ST_READ && mem_ack) begin
      mem_rd_q.req  <= 1'b0;
    end
  end

  // Byte held aside; memory side has no write path at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= RST_DATA;
    end else if (state_q == ST_READ && mem_ack) begin
      data_q <= mem_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= RST_ACC;
    end else if (wr_en && is_reg(paddr, OFS_ACC)) begin
      acc_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pointer_q <= RST_POINTER;
    end else if (state_q == ST_EXEC) begin
      pointer_q <= pointer_d;
    end else if (wr_en && is_reg(paddr, OFS_POINTER)) begin
      pointer_q <= pwdata[15:0];
    end
  end

  // counter step; zero wraps to all ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_q <= RST_COUNTER;
    end else if (state_q == ST_EXEC) begin
      counter_q <= counter_d;
    end else if (wr_en && is_reg(paddr, OFS_COUNTER)) begin
      counter_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= RST_FLAGS;
    end else if (state_q == ST_EXEC) begin
      flags_q <= flags_d;
    end else if (wr_en && is_reg(paddr, OFS_FLAGS)) begin
      flags_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode_q <= RST_OPCODE;
    end else if (wr_en && is_reg(paddr, OFS_OPCODE)) begin
      opcode_q <= pwdata[15:0];
    end
  end

  // Done and bad opcode reported; a new start clears done and sets bad opcode only for a foreign opcode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q   <= 1'b0;
      bad_op_q <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      busy_q <= (state_q == ST_IDLE) ? (start && op_ok)
                                     : (state_q != ST_EXEC);
      if (state_q == ST_EXEC) begin
        done_q <= 1'b1;
      end else if (start) begin
        done_q <= 1'b0;
      end
      // foreign opcode is flagged, not run
      if (start) begin
        bad_op_q <= !op_ok;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign mem_rd  = mem_rd_q;
  assign busy    = busy_q;

  // Helpers for the checks below
  logic [7:0] diff_w;
  logic       half_w;
  assign diff_w = 8'(acc_q - data_q);
  assign half_w = (acc_q[3:0] < data_q[3:0]);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_read_addr;
    (state_q == ST_READ) |-> (mem_rd_q.req && mem_rd_q.addr == pointer_q);
  endproperty
  a_read_addr: assert property (p_read_addr)
    else $error("read address differs from string pointer");

  property p_acc_kept;
    (state_q == ST_EXEC) |=> (acc_q == $past(acc_q));
  endproperty
  a_acc_kept: assert property (p_acc_kept)
    else $error("accumulator changed by compare");

  property p_zero;
    (state_q == ST_EXEC) |=> (flags_q.zero == ($past(diff_w) == 8'h00));
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");

  property p_sign;
    (state_q == ST_EXEC) ##1 1'b1 |-> (flags_q.sign == $past(diff_w[7]));
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign flag wrong");

  property p_pointer;
    (state_q == ST_EXEC) |=> (pointer_q == 16'($past(pointer_q) + 16'h0001));
  endproperty
  a_pointer: assert property (p_pointer)
    else $error("pointer not advanced by one");

  property p_counter;
    (state_q == ST_EXEC) |=> (counter_q == 16'($past(counter_q) - 16'h0001));
  endproperty
  a_counter: assert property (p_counter)
    else $error("counter not decremented by one");

  property p_half;
    (state_q == ST_EXEC) |=> (flags_q.half == $past(half_w));
  endproperty
  a_half: assert property (p_half)
    else $error("half flag wrong");

  property p_count_nz;
    (state_q == ST_EXEC) |=> (flags_q.count_nz == (counter_q != 16'h0000));
  endproperty
  a_count_nz: assert property (p_count_nz)
    else $error("count flag wrong");

  property p_bad_op;
    (start && !op_ok) |=> (state_q == ST_IDLE && bad_op_q && !mem_rd_q.req);
  endproperty
  a_bad_op: assert property (p_bad_op)
    else $error("foreign opcode was executed");

  property p_sub_carry;
    (state_q == ST_EXEC) |=> (flags_q.subtract && flags_q.carry == $past(flags_q.carry));
  endproperty
  a_sub_carry: assert property (p_sub_carry)
    else $error("subtract or carry flag wrong");

  property p_diff_sub;
    (state_q == ST_EXEC) |-> (flags_d.sign == diff_w[7] && flags_d.zero == (acc_q == data_q));
  endproperty
  a_diff_sub: assert property (p_diff_sub)
    else $error("difference not two's complement");

  property p_byte_taken;
    (state_q == ST_READ && mem_ack) |=> (data_q == $past(mem_rdata));
  endproperty
  a_byte_taken: assert property (p_byte_taken)
    else $error("byte from memory not taken");

  // Waiting for memory must not move the pointer pair early
  property p_wait_hold;
    (state_q == ST_READ && !mem_ack) |=> (state_q == ST_READ && pointer_q == $past(pointer_q)
                                          && counter_q == $past(counter_q));
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("pointer or counter moved before the byte arrived");

  c_match:   cover property ((state_q == ST_EXEC) ##1 flags_q.zero);
  c_last:    cover property ((state_q == ST_EXEC) ##1 !flags_q.count_nz);
  c_bad_op:  cover property (start && !op_ok);
  c_wrap:    cover property ((state_q == ST_EXEC) && (counter_q == 16'h0000));

endmodule
`default_nettype wire

// *** tb/mem_model.sv ***
`default_nettype none
module mem_model
  import compare_step_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire mem_rd_t    mem_rd,
  input  wire logic [3:0] lag,
  output logic      [7:0] mem_rdata,
  output logic            mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q = 4'h0;
  logic       ack_q = 1'b0;
  logic [7:0] dat_q = 8'h00;

  assign mem_ack = ack_q;
  assign mem_rdata = dat_q;

  // Read-only store; data line toggles when not answering
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      ack_q <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      dat_q <= ~dat_q;
      if (mem_rd.req && !ack_q) begin
        if (cnt_q >= lag) begin
          ack_q <= 1'b1;
          dat_q <= mem_rd.addr[7:0] ^ 8'h5a;
          cnt_q <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/test_compare_and_step_unit.sv ***
`default_nettype none
module test_compare_and_step_unit
  import compare_step_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  lag = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mem_ack;
  logic        busy;
  logic [7:0]  mem_rdata;
  mem_rd_t     mem_rd;
  logic [31:0] rd;
  logic        er;
  int          err_count = 0;
  int          checks = 0;
  int          seed = 67;

  always #5 pclk = ~pclk;

  compare_and_step_unit compare_and_step_unit_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy));

  mem_model mem_model_i (.pclk(pclk), .presetn(presetn), .mem_rd(mem_rd), .lag(lag),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One idle cycle after each transfer keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic step(input int a, input int p, input int c, input int f, input logic [3:0] l);
    int b, dif, cn, ef;
    b = (p & 255) ^ 8'h5a;
    dif = (a - b) & 255;
    cn = (c - 1) & 16'hffff;
    ef = (dif & 128) | ((a == b) ? 64 : 0) | (f & 8'h29) | (((a & 15) < (b & 15)) ? 16 : 0);
    ef = ef | ((cn != 0) ? 4 : 0) | 2;
    lag <= l;
    wr(OFS_OPCODE, {16'h0, COMPARE_STEP_OP});
    wr(OFS_ACC, 32'(a));
    wr(OFS_POINTER, 32'(p));
    wr(OFS_COUNTER, 32'(c));
    wr(OFS_FLAGS, 32'(f));
    wr(OFS_CTRL, 32'h1);
    while (mem_rd.req !== 1'b1) begin
      @(posedge pclk);
    end
    chk({16'h0, mem_rd.addr}, 32'(p)); // read address
    chk({31'h0, busy}, 32'h1); // busy while reading
    // Slow answer leaves room for a refused write
    if (l > 5) begin
      wr(OFS_ACC, 32'h0);
      chk({31'h0, er}, 32'h1); // write refused
    end
    while (busy !== 1'b0) begin
      @(posedge pclk);
    end
    rchk(OFS_FLAGS, 32'(ef));
    rchk(OFS_POINTER, 32'((p + 1) & 16'hffff)); // pointer step
    rchk(OFS_COUNTER, 32'(cn)); // counter step
    rchk(OFS_ACC, 32'(a)); // accumulator kept
    rchk(OFS_DATA, 32'(b)); // byte read
    rchk(OFS_STATUS, 32'h2); // done, no fault
  endtask

  initial begin
    logic [15:0] bad_op [2];
    int          a, p, c, f;
    bad_op[0] = 16'hedb1;
    bad_op[1] = 16'hcda1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      rchk(8'(4 * i), 32'h0);
    end
    $display("test reset values done");
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    wr(OFS_STATUS, 32'hff);
    rchk(OFS_STATUS, 32'h0);
    $display("test unmapped and read-only done");
    for (int i = 0; i < 2; i++) begin
      wr(OFS_OPCODE, {16'h0, bad_op[i]});
      wr(OFS_CTRL, 32'h1);
      chk({31'h0, mem_rd.req}, 32'h0); // no read started
      rchk(OFS_STATUS, 32'h4); // opcode refused
      rchk(OFS_POINTER, 32'h0); // pointer untouched
    end
    $display("test wrong opcodes done");
    for (int i = 0; i < 24; i++) begin
      p = $random(seed) & 16'hffff;
      a = $random(seed) & 255;
      c = $random(seed) & 16'hffff;
      f = $random(seed) & 255;
      // Equal bytes with last count, then counter and pointer wrap
      if (i == 0) begin
        a = (p & 255) ^ 8'h5a;
        c = 1;
      end
      if (i == 1) begin
        c = 0;
        p = 16'hffff;
      end
      step(a, p, c, f, (i == 2) ? 4'hf : 4'($random(seed)));
    end
    $display("test compare steps done");
    give_verdict();
  end

  initial begin
    #100000;
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
